// >>> rtl/cale_exec.sv
// Execution datapath: arithmetic, logic, multiply, jump, call and return.
`timescale 1ns/10ps

module cale_exec (
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               start,
	input  wire cale_pkg::cale_req_t req,
	output logic                    ready,
	output logic                    done,
	output cale_pkg::cale_res_t     res
);

	// =====================================================================
	// Flag helpers
	function automatic cale_pkg::cale_alu_t add8(input logic [7:0] d, input logic [7:0] s,
		input logic ci);
		cale_pkg::cale_alu_t a;
		logic [8:0]          w;
		w   = {1'b0, d} + {1'b0, s} + {8'h00, ci};
		a.r = w[7:0];
		a.c = w[8];
		a.h = (d[3] & s[3]) | (s[3] & ~a.r[3]) | (~a.r[3] & d[3]);
		a.v = (d[7] & s[7] & ~a.r[7]) | (~d[7] & ~s[7] & a.r[7]);
		return a;
	endfunction

	function automatic cale_pkg::cale_alu_t sub8(input logic [7:0] d, input logic [7:0] s,
		input logic ci);
		cale_pkg::cale_alu_t a;
		logic [8:0]          w;
		w   = {1'b0, d} - {1'b0, s} - {8'h00, ci};
		a.r = w[7:0];
		a.c = w[8];
		a.h = (~d[3] & s[3]) | (s[3] & a.r[3]) | (a.r[3] & ~d[3]);
		a.v = (d[7] & ~s[7] & ~a.r[7]) | (~d[7] & s[7] & a.r[7]);
		return a;
	endfunction

	// Applies Z C N V H; chained subtracts only keep Z when it was already set.
	function automatic cale_pkg::cale_sreg_t arith_fl(input cale_pkg::cale_sreg_t f,
		input cale_pkg::cale_alu_t a, input logic chain);
		cale_pkg::cale_sreg_t o;
		o   = f;
		o.c = a.c;
		o.h = a.h;
		o.v = a.v;
		o.n = a.r[7];
		o.z = (a.r == cale_pkg::ALL_ZEROS) & (~chain | f.z);
		return o;
	endfunction

	// Applies Z N and the given V, leaving C and H alone.
	function automatic cale_pkg::cale_sreg_t znv_fl(input cale_pkg::cale_sreg_t f,
		input logic [7:0] r, input logic v);
		cale_pkg::cale_sreg_t o;
		o   = f;
		o.z = (r == cale_pkg::ALL_ZEROS);
		o.n = r[7];
		o.v = v;
		return o;
	endfunction

	// =====================================================================
	// Operation decode and result calculation
	cale_pkg::cale_res_t   nx;
	cale_pkg::cale_alu_t   ar;
	logic [2:0]            cyc;
	logic [7:0]            src;
	logic [7:0]            lr;
	logic [15:0]           wr;
	logic [15:0]           rel_target;
	logic signed [17:0]    prod;
	logic [15:0]           pr;
	logic                  sa, sb;

	// Register or immediate second operand, relative target and the product.
	always_comb begin
		src = req.src_reg;
		if (req.op inside {cale_pkg::op_sub_imm, cale_pkg::op_sub_imm_with_carry,
			cale_pkg::op_conj_imm, cale_pkg::op_disj_imm}) begin
			src = req.imm;
		end
		rel_target = 16'(req.pc + {{(16 - cale_pkg::OFFSET_W){req.offset[11]}}, req.offset}
			+ 16'h0001);
		sa = req.op inside {cale_pkg::op_mult_signed, cale_pkg::op_mult_signed_unsigned,
			cale_pkg::op_frac_mult_signed, cale_pkg::op_frac_mult_signed_unsigned};
		sb = req.op inside {cale_pkg::op_mult_signed, cale_pkg::op_frac_mult_signed};
		prod = $signed({sa & req.rd[7], req.rd}) *
			$signed({sb & req.src_reg[7], req.src_reg});
		pr = prod[15:0];
	end

	// Result, flags, write enables and cycle count of the requested operation.
	always_comb begin
		nx      = '0;
		nx.sreg = req.sreg;
		cyc     = cale_pkg::CYC_ALU;
		ar      = '0;
		lr      = '0;
		wr      = '0;
		case (req.op)
			cale_pkg::op_add_regs, cale_pkg::op_add_carry: begin
				ar = add8(req.rd, req.src_reg,
					(req.op == cale_pkg::op_add_carry) & req.sreg.c);
				nx.sreg = arith_fl(req.sreg, ar, 1'b0);
			end
			cale_pkg::op_sub_regs, cale_pkg::op_sub_imm: begin
				ar = sub8(req.rd, src, 1'b0);
				nx.sreg = arith_fl(req.sreg, ar, 1'b0);
			end
			cale_pkg::op_sub_regs_with_carry, cale_pkg::op_sub_imm_with_carry: begin
				ar = sub8(req.rd, src, req.sreg.c);
				nx.sreg = arith_fl(req.sreg, ar, 1'b1);
			end
			cale_pkg::op_twos_complement: begin
				ar = sub8(cale_pkg::ALL_ZEROS, req.rd, 1'b0);
				nx.sreg = arith_fl(req.sreg, ar, 1'b0);
			end
			default: ;
		endcase
		case (req.op)
			cale_pkg::op_conj_regs, cale_pkg::op_conj_imm, cale_pkg::op_test_zero_minus:
				lr = req.rd & ((req.op == cale_pkg::op_test_zero_minus) ? req.rd : src);
			cale_pkg::op_disj_regs, cale_pkg::op_disj_imm: lr = req.rd | src;
			cale_pkg::op_xor_regs: lr = req.rd ^ req.src_reg;
			cale_pkg::op_clear_reg: lr = req.rd ^ req.rd;
			cale_pkg::op_set_bits_mask: lr = req.rd | req.imm;
			cale_pkg::op_clear_bits_mask: lr = req.rd & (cale_pkg::ALL_ONES - req.imm);
			cale_pkg::op_increment_reg: lr = 8'(req.rd + 8'h01);
			cale_pkg::op_decrement_reg: lr = 8'(req.rd - 8'h01);
			cale_pkg::op_ones_complement: lr = cale_pkg::ALL_ONES - req.rd;
			cale_pkg::op_set_reg_all_ones: lr = cale_pkg::ALL_ONES;
			default: lr = ar.r;
		endcase
		case (req.op)
			cale_pkg::op_add_regs, cale_pkg::op_add_carry, cale_pkg::op_sub_regs,
			cale_pkg::op_sub_imm, cale_pkg::op_sub_regs_with_carry,
			cale_pkg::op_sub_imm_with_carry, cale_pkg::op_twos_complement,
			cale_pkg::op_set_reg_all_ones: begin
				nx.result = {8'h00, lr};
				nx.reg_wr = 1'b1;
			end
			cale_pkg::op_conj_regs, cale_pkg::op_conj_imm, cale_pkg::op_disj_regs,
			cale_pkg::op_disj_imm, cale_pkg::op_xor_regs, cale_pkg::op_test_zero_minus,
			cale_pkg::op_clear_reg, cale_pkg::op_set_bits_mask,
			cale_pkg::op_clear_bits_mask: begin
				nx.result = {8'h00, lr};
				nx.reg_wr = 1'b1;
				nx.sreg = znv_fl(req.sreg, lr, 1'b0);
			end
			cale_pkg::op_increment_reg, cale_pkg::op_decrement_reg: begin
				nx.result = {8'h00, lr};
				nx.reg_wr = 1'b1;
				nx.sreg = znv_fl(req.sreg, lr, (req.op == cale_pkg::op_increment_reg) ?
					(lr == cale_pkg::MOST_NEG) : (lr == cale_pkg::MOST_POS));
			end
			cale_pkg::op_ones_complement: begin
				nx.result = {8'h00, lr};
				nx.reg_wr = 1'b1;
				nx.sreg = znv_fl(req.sreg, lr, 1'b0);
				nx.sreg.c = 1'b1;
			end
			cale_pkg::op_add_imm_word, cale_pkg::op_sub_imm_word: begin
				cyc = cale_pkg::CYC_WORD;
				if (req.op == cale_pkg::op_add_imm_word) begin
					wr = 16'(req.word + {10'h000, req.imm[cale_pkg::WORD_IMM_W-1:0]});
					nx.sreg.v = ~req.word[15] & wr[15];
					nx.sreg.c = ~wr[15] & req.word[15];
				end else begin
					wr = 16'(req.word - {10'h000, req.imm[cale_pkg::WORD_IMM_W-1:0]});
					nx.sreg.v = req.word[15] & ~wr[15];
					nx.sreg.c = wr[15] & ~req.word[15];
				end
				nx.sreg.n = wr[15];
				nx.sreg.z = (wr == 16'h0000);
				nx.sreg.s = wr[15] ^ nx.sreg.v;
				nx.result = wr;
				nx.pair_wr = 1'b1;
			end
			cale_pkg::op_mult_unsigned, cale_pkg::op_mult_signed,
			cale_pkg::op_mult_signed_unsigned: begin
				cyc = cale_pkg::CYC_MUL;
				nx.result = pr;
				nx.prod_wr = 1'b1;
				nx.sreg.c = pr[15];
				nx.sreg.z = (pr == 16'h0000);
			end
			cale_pkg::op_frac_mult_unsigned, cale_pkg::op_frac_mult_signed,
			cale_pkg::op_frac_mult_signed_unsigned: begin
				cyc = cale_pkg::CYC_MUL;
				nx.result = {pr[14:0], 1'b0};
				nx.prod_wr = 1'b1;
				nx.sreg.c = pr[15];
				nx.sreg.z = ({pr[14:0], 1'b0} == 16'h0000);
			end
			cale_pkg::op_relative_jump, cale_pkg::op_pointer_jump,
			cale_pkg::op_direct_jump: begin
				nx.pc_wr = 1'b1;
				cyc = (req.op == cale_pkg::op_direct_jump) ? cale_pkg::CYC_DJUMP :
					cale_pkg::CYC_JUMP;
				nx.pc_target = (req.op == cale_pkg::op_relative_jump) ? rel_target :
					(req.op == cale_pkg::op_pointer_jump) ? req.zptr : req.addr;
			end
			cale_pkg::op_relative_subcall, cale_pkg::op_pointer_subcall,
			cale_pkg::op_direct_subcall: begin
				nx.pc_wr = 1'b1;
				nx.push_wr = 1'b1;
				cyc = (req.op == cale_pkg::op_direct_subcall) ? cale_pkg::CYC_DCALL :
					cale_pkg::CYC_CALL;
				nx.pc_target = (req.op == cale_pkg::op_relative_subcall) ? rel_target :
					(req.op == cale_pkg::op_pointer_subcall) ? req.zptr : req.addr;
				// Direct call is two words long, so it returns one word further on.
				nx.push_addr = (req.op == cale_pkg::op_direct_subcall) ?
					16'(req.pc + 16'h0002) : 16'(req.pc + 16'h0001);
			end
			cale_pkg::op_sub_return, cale_pkg::op_interrupt_return: begin
				cyc = cale_pkg::CYC_RETURN;
				nx.pc_wr = 1'b1;
				nx.pc_target = req.stack;
				if (req.op == cale_pkg::op_interrupt_return) begin
					nx.sreg.i = 1'b1;
				end
			end
			default: ;
		endcase
	end

	// =====================================================================
	// Sequencing
	cale_pkg::cale_state_t state_reg;
	logic [2:0]            cnt_reg;
	cale_pkg::cale_res_t   res_reg;
	logic                  take;

	// A new request is accepted while idle or in the final cycle of the previous one.
	assign done  = (state_reg == cale_pkg::st_busy) && (cnt_reg == 3'h1);
	assign ready = (state_reg == cale_pkg::st_idle) || done;
	assign take  = start && ready;

	// State and remaining cycle count.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= cale_pkg::st_idle;
			cnt_reg   <= 3'h0;
		end else begin
			case (state_reg)
				cale_pkg::st_idle: begin
					if (take) begin
						state_reg <= cale_pkg::st_busy;
						cnt_reg   <= cyc;
					end
				end
				cale_pkg::st_busy: begin
					if (take) begin
						cnt_reg <= cyc;
					end else if (done) begin
						state_reg <= cale_pkg::st_idle;
						cnt_reg   <= 3'h0;
					end else begin
						cnt_reg <= 3'(cnt_reg - 3'h1);
					end
				end
				default: state_reg <= cale_pkg::st_idle;
			endcase
		end
	end

	// Results are captured when the request is taken and held until the next one.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			res_reg <= '0;
		end else if (take) begin
			res_reg <= nx;
		end
	end

	// Write strobes only show in the completing cycle.
	always_comb begin
		res         = res_reg;
		res.reg_wr  = res_reg.reg_wr & done;
		res.pair_wr = res_reg.pair_wr & done;
		res.prod_wr = res_reg.prod_wr & done;
		res.pc_wr   = res_reg.pc_wr & done;
		res.push_wr = res_reg.push_wr & done;
	end

	// =====================================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	add_result_a: assert property (take && req.op == cale_pkg::op_add_regs |=> done &&
		res.reg_wr && res.result[7:0] == 8'($past(req.rd) + $past(req.src_reg)))
		else $error("add result or timing wrong");
	word_timing_a: assert property (take && req.op == cale_pkg::op_add_imm_word |=>
		!done ##1 done && res.pair_wr && res.sreg.s == (res.sreg.n ^ res.sreg.v))
		else $error("word add timing or sign wrong");
	sub_borrow_a: assert property (take && req.op == cale_pkg::op_sub_regs |=>
		res.sreg.c == ($past(req.src_reg) > $past(req.rd)))
		else $error("subtract borrow wrong");
	chain_zero_a: assert property (take && req.op == cale_pkg::op_sub_regs_with_carry &&
		!req.sreg.z |=> done && !res.sreg.z)
		else $error("chained zero flag set");
	logic_flags_a: assert property (take && req.op == cale_pkg::op_xor_regs |=>
		!res.sreg.v && res.sreg.c == $past(req.sreg.c) && res.sreg.h == $past(req.sreg.h))
		else $error("logic op touched wrong flags");
	clear_mask_a: assert property (take && req.op == cale_pkg::op_clear_bits_mask |=>
		res.result[7:0] == ($past(req.rd) & ~$past(req.imm)))
		else $error("clear bits result wrong");
	set_ones_a: assert property (take && req.op == cale_pkg::op_set_reg_all_ones |=>
		res.result[7:0] == 8'hff && res.sreg == $past(req.sreg))
		else $error("set all ones wrong");
	mult_product_a: assert property (take && req.op == cale_pkg::op_mult_unsigned |=>
		!done ##1 done && res.prod_wr &&
		res.result == 16'($past(req.rd, 2) * $past(req.src_reg, 2)))
		else $error("unsigned product wrong");
	frac_carry_a: assert property (take && req.op == cale_pkg::op_frac_mult_unsigned |=>
		res.result[0] == 1'b0 && res.sreg.c == $past(pr[15]))
		else $error("fractional product wrong");
	rel_jump_a: assert property (take && req.op == cale_pkg::op_relative_jump |=>
		!done ##1 done && res.pc_wr && res.sreg == $past(req.sreg, 2))
		else $error("relative jump wrong");
	direct_call_a: assert property (take && req.op == cale_pkg::op_direct_subcall |=>
		!done [*3] ##1 done && res.push_wr && res.pc_wr)
		else $error("direct call timing wrong");
	irq_return_a: assert property (take && req.op == cale_pkg::op_interrupt_return |=>
		!done [*3] ##1 done && res.pc_wr && res.sreg.i)
		else $error("interrupt return wrong");

endmodule

// >>> rtl/cale_pkg.sv
// Shared types and constants for the arithmetic, logic and branch execution block.
package cale_pkg;

	// =====================================================================
	// Operation codes
	typedef enum logic [5:0] {
		op_add_regs, op_add_carry, op_add_imm_word, op_sub_regs, op_sub_imm,
		op_sub_regs_with_carry, op_sub_imm_with_carry, op_sub_imm_word,
		op_conj_regs, op_conj_imm, op_disj_regs, op_disj_imm, op_xor_regs,
		op_ones_complement, op_twos_complement, op_set_bits_mask, op_clear_bits_mask,
		op_increment_reg, op_decrement_reg, op_test_zero_minus, op_clear_reg,
		op_set_reg_all_ones, op_mult_unsigned, op_mult_signed, op_mult_signed_unsigned,
		op_frac_mult_unsigned, op_frac_mult_signed, op_frac_mult_signed_unsigned,
		op_relative_jump, op_pointer_jump, op_direct_jump, op_relative_subcall,
		op_pointer_subcall, op_direct_subcall, op_sub_return, op_interrupt_return
	} cale_op_t;

	// =====================================================================
	// Execution states
	typedef enum logic [1:0] {
		st_idle = 2'b01,
		st_busy = 2'b10
	} cale_state_t;

	// =====================================================================
	// Constants and cycle counts
	localparam logic [7:0] ALL_ONES   = 8'hff;
	localparam logic [7:0] ALL_ZEROS  = 8'h00;
	localparam logic [7:0] MOST_NEG   = 8'h80;
	localparam logic [7:0] MOST_POS   = 8'h7f;
	localparam int         WORD_IMM_W = 6;
	localparam int         OFFSET_W   = 12;
	localparam logic [2:0] CYC_ALU    = 3'h1;
	localparam logic [2:0] CYC_WORD   = 3'h2;
	localparam logic [2:0] CYC_MUL    = 3'h2;
	localparam logic [2:0] CYC_JUMP   = 3'h2;
	localparam logic [2:0] CYC_DJUMP  = 3'h3;
	localparam logic [2:0] CYC_CALL   = 3'h3;
	localparam logic [2:0] CYC_DCALL  = 3'h4;
	localparam logic [2:0] CYC_RETURN = 3'h4;

	// =====================================================================
	// Carriers
	typedef struct packed {
		logic i, t, h, s, v, n, z, c;
	} cale_sreg_t;

	typedef struct packed {
		logic [7:0] r;
		logic       c, h, v;
	} cale_alu_t;

	typedef struct packed {
		cale_op_t              op;
		logic [7:0]            rd, src_reg, imm;
		logic [15:0]           word, pc, zptr, addr, stack;
		logic [OFFSET_W-1:0]   offset;
		cale_sreg_t            sreg;
	} cale_req_t;

	typedef struct packed {
		logic [15:0] result;
		cale_sreg_t  sreg;
		logic        reg_wr, pair_wr, prod_wr, pc_wr, push_wr;
		logic [15:0] pc_target, push_addr;
	} cale_res_t;

endpackage

// >>> test/cale_core_model.sv
// Model of the program counter and return address logic beside the execution block.
`timescale 1ns/10ps
module cale_core_model (
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic                done,
	input  wire cale_pkg::cale_res_t res,
	output logic [15:0]              pc,
	output logic [15:0]              stack_top
);
	// =====================================================================
	// Program counter
	// Follows every jump, call and return so the next request starts from it.
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			pc <= 16'h0000;
		else if (done && res.pc_wr)
			pc <= res.pc_target;
	end

	// Keeps the last pushed return address for the following return.
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			stack_top <= 16'h0000;
		else if (done && res.push_wr)
			stack_top <= res.push_addr;
	end
endmodule

// >>> test/tb_cale_exec.sv
// Self-checking testbench for the execution datapath.
`timescale 1ns/10ps
module tb_cale_exec;
	typedef struct packed {
		cale_pkg::cale_res_t r;
		logic [2:0]          cyc;
	} cale_note_t;
	logic                clk;
	logic                reset;
	logic                start;
	cale_pkg::cale_req_t req;
	cale_pkg::cale_req_t q;
	logic                ready;
	logic                done;
	cale_pkg::cale_res_t res;
	logic [15:0]         pc;
	logic [15:0]         stack_top;
	cale_note_t          notes[$];
	cale_note_t          e;
	int                  takes[$];
	int                  t;
	int                  cyc;
	int                  fails;
	int                  compares;
	int                  seed;
	int                  n;
	int                  pass;

	cale_exec dut_u (.clk(clk), .reset(reset), .start(start), .req(req), .ready(ready),
		.done(done), .res(res));
	cale_core_model model_u (.clk(clk), .reset(reset), .done(done), .res(res), .pc(pc),
		.stack_top(stack_top));

	// =====================================================================
	// Expected results
	// Works out the response that a request must give.
	function automatic cale_note_t expect_of(input cale_pkg::cale_req_t q);
		cale_note_t        e;
		logic [8:0]        s;
		logic [4:0]        h5;
		logic [7:0]        a;
		logic [7:0]        b;
		logic [15:0]       p;
		logic signed [8:0] sa;
		logic signed [8:0] sb;
		logic              ci;
		logic              v;
		logic              lg;
		logic              zc;
		logic [4:0]        m;
		e = '0;
		e.r.sreg = q.sreg;
		e.cyc = 3'h2;
		lg = 1'b1;
		m = 5'b00111;
		case (q.op)
		cale_pkg::op_add_imm_word, cale_pkg::op_sub_imm_word: begin
			v = q.op == cale_pkg::op_add_imm_word;
			p = v ? q.word + {10'h000, q.imm[5:0]} : q.word - {10'h000, q.imm[5:0]};
			e.r.sreg.c = v ? (q.word[15] & !p[15]) : (p[15] & !q.word[15]);
			e.r.sreg.v = v ? (!q.word[15] & p[15]) : (q.word[15] & !p[15]);
			e.r.sreg.n = p[15];
			e.r.sreg.z = p == 16'h0000;
			e.r.sreg.s = p[15] ^ e.r.sreg.v;
			e.r.result = p;
			e.r.pair_wr = 1'b1;
			return e;
		end
		cale_pkg::op_mult_unsigned, cale_pkg::op_mult_signed, cale_pkg::op_mult_signed_unsigned,
		cale_pkg::op_frac_mult_unsigned, cale_pkg::op_frac_mult_signed,
		cale_pkg::op_frac_mult_signed_unsigned: begin
			lg = q.op inside {cale_pkg::op_mult_signed, cale_pkg::op_frac_mult_signed};
			zc = lg || q.op inside {cale_pkg::op_mult_signed_unsigned,
				cale_pkg::op_frac_mult_signed_unsigned};
			sa = {q.rd[7] & zc, q.rd};
			sb = {q.src_reg[7] & lg, q.src_reg};
			p = sa * sb;
			e.r.sreg.c = p[15];
			if (q.op inside {cale_pkg::op_frac_mult_unsigned, cale_pkg::op_frac_mult_signed,
				cale_pkg::op_frac_mult_signed_unsigned})
				p = p << 1;
			e.r.sreg.z = p == 16'h0000;
			e.r.result = p;
			e.r.prod_wr = 1'b1;
			return e;
		end
		cale_pkg::op_relative_jump, cale_pkg::op_pointer_jump, cale_pkg::op_direct_jump,
		cale_pkg::op_relative_subcall, cale_pkg::op_pointer_subcall, cale_pkg::op_direct_subcall,
		cale_pkg::op_sub_return, cale_pkg::op_interrupt_return: begin
			e.r.pc_wr = 1'b1;
			e.r.pc_target = q.pc + {{4{q.offset[11]}}, q.offset} + 16'h0001;
			if (q.op inside {cale_pkg::op_pointer_jump, cale_pkg::op_pointer_subcall})
				e.r.pc_target = q.zptr;
			if (q.op inside {cale_pkg::op_direct_jump, cale_pkg::op_direct_subcall})
				e.r.pc_target = q.addr;
			if (q.op inside {cale_pkg::op_sub_return, cale_pkg::op_interrupt_return})
				e.r.pc_target = q.stack;
			e.r.push_wr = q.op inside {cale_pkg::op_relative_subcall, cale_pkg::op_pointer_subcall,
				cale_pkg::op_direct_subcall};
			e.r.push_addr = q.pc + ((q.op == cale_pkg::op_direct_subcall) ? 16'h0002 : 16'h0001);
			e.r.sreg.i = q.sreg.i | (q.op == cale_pkg::op_interrupt_return);
			e.cyc = q.op inside {cale_pkg::op_relative_jump, cale_pkg::op_pointer_jump} ? 3'h2
				: q.op inside {cale_pkg::op_direct_subcall, cale_pkg::op_sub_return,
				cale_pkg::op_interrupt_return} ? 3'h4 : 3'h3;
			return e;
		end
		default: ;
		endcase
		e.cyc = 3'h1;
		e.r.reg_wr = 1'b1;
		a = (q.op == cale_pkg::op_twos_complement) ? 8'h00 : q.rd;
		b = q.op inside {cale_pkg::op_sub_imm, cale_pkg::op_sub_imm_with_carry} ? q.imm
			: q.src_reg;
		if (q.op inside {cale_pkg::op_increment_reg, cale_pkg::op_decrement_reg})
			b = 8'h01;
		if (q.op == cale_pkg::op_twos_complement)
			b = q.rd;
		zc = q.op inside {cale_pkg::op_sub_regs_with_carry, cale_pkg::op_sub_imm_with_carry};
		ci = (zc || q.op == cale_pkg::op_add_carry) & q.sreg.c;
		s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		h5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		v = (a[7] == b[7]) && (s[7] != a[7]);
		if (q.op inside {cale_pkg::op_sub_regs, cale_pkg::op_sub_imm, cale_pkg::op_decrement_reg,
			cale_pkg::op_twos_complement} || zc) begin
			s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
			h5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
			v = (a[7] != b[7]) && (s[7] != a[7]);
		end
		if (q.op inside {cale_pkg::op_add_regs, cale_pkg::op_add_carry, cale_pkg::op_sub_regs,
			cale_pkg::op_sub_imm, cale_pkg::op_twos_complement} || zc)
			m = 5'b11111;
		case (q.op)
		cale_pkg::op_conj_regs: s = {1'b0, a & b};
		cale_pkg::op_conj_imm: s = {1'b0, a & q.imm};
		cale_pkg::op_disj_regs: s = {1'b0, a | b};
		cale_pkg::op_disj_imm, cale_pkg::op_set_bits_mask: s = {1'b0, a | q.imm};
		cale_pkg::op_xor_regs: s = {1'b0, a ^ b};
		cale_pkg::op_clear_bits_mask: s = {1'b0, a & (8'hff - q.imm)};
		cale_pkg::op_test_zero_minus: s = {1'b0, a};
		cale_pkg::op_clear_reg: s = 9'h000;
		cale_pkg::op_ones_complement: s = {1'b1, 8'hff - a};
		cale_pkg::op_set_reg_all_ones: s = 9'h0ff;
		default: lg = 1'b0;
		endcase
		if (q.op == cale_pkg::op_ones_complement)
			m = 5'b01111;
		if (q.op == cale_pkg::op_set_reg_all_ones)
			m = 5'b00000;
		if (lg)
			v = 1'b0;
		if (m[4])
			e.r.sreg.h = h5[4];
		if (m[3])
			e.r.sreg.c = s[8];
		if (m[2])
			e.r.sreg.v = v;
		if (m[1])
			e.r.sreg.n = s[7];
		if (m[0])
			e.r.sreg.z = (s[7:0] == 8'h00) && (q.sreg.z || !zc);
		e.r.result = {8'h00, s[7:0]};
		return e;
	endfunction

	// =====================================================================
	// Checking and ending
	// Counts one comparison and reports it when it fails.
	task automatic check(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			fails++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Makes the 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Watches every edge: matches each done pulse with the oldest note and its take edge.
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (done === 1'b1) begin
			e = notes.pop_front();
			t = takes.pop_front();
			check(cyc - t == int'(e.cyc), "cycle count");
			check(res.sreg === e.r.sreg, "status flags");
			check({res.reg_wr, res.pair_wr, res.prod_wr, res.pc_wr, res.push_wr} === {e.r.reg_wr,
				e.r.pair_wr, e.r.prod_wr, e.r.pc_wr, e.r.push_wr}, "write strobes");
			check(!e.r.reg_wr || res.result[7:0] === e.r.result[7:0], "byte result");
			check(!(e.r.pair_wr || e.r.prod_wr) || res.result === e.r.result, "word");
			check(!e.r.pc_wr || res.pc_target === e.r.pc_target, "jump target");
			check(!e.r.push_wr || res.push_addr === e.r.push_addr, "return addr");
		end else if (takes.size() > 0)
			check(ready === 1'b0, "ready while busy");
		if (reset === 1'b0 && start === 1'b1 && ready === 1'b1)
			takes.push_back(cyc);
	end

	// Offers one request and holds it until it is taken, with an optional idle cycle after.
	task automatic issue(input cale_pkg::cale_req_t q, input logic gap);
		int i;
		start <= 1'b1;
		req <= q;
		notes.push_back(expect_of(q));
		for (i = 0; i < 10; i++) begin
			@(posedge clk);
			if (ready === 1'b1)
				break;
		end
		if (i == 10) begin
			fails++;
			stop_test();
		end
		if (gap) begin
			start <= 1'b0;
			@(posedge clk);
		end
	endtask

	// Picks an operand, often a boundary value.
	function automatic logic [7:0] pick();
		case ($unsigned($random(seed)) % 6)
		0: return 8'h00;
		1: return 8'h7f;
		2: return 8'h80;
		3: return 8'hff;
		4: return 8'h01;
		default: return 8'($random(seed));
		endcase
	endfunction

	// Resets, then runs every operation first spaced, then back to back.
	initial begin
		seed = 32'h968a;
		cyc = 0;
		fails = 0;
		compares = 0;
		reset = 1'b1;
		start = 1'b0;
		req = '0;
		repeat (16) @(posedge clk);
		check(ready === 1'b1 && done === 1'b0 && res === '0, "reset state");
		reset <= 1'b0;
		@(posedge clk);
		for (pass = 0; pass < 2; pass++) begin
			for (n = 0; n < 36 * 8; n++) begin
				q = '0;
				q.op = cale_pkg::cale_op_t'(n % 36);
				q.rd = pick();
				q.src_reg = pick();
				q.imm = pick();
				q.word = {pick(), pick()};
				q.pc = pc;
				q.stack = stack_top;
				q.zptr = 16'($random(seed));
				q.addr = 16'($random(seed));
				q.offset = 12'($random(seed));
				q.sreg = 8'($random(seed));
				issue(q, pass == 0);
			end
			start <= 1'b0;
			repeat (6) @(posedge clk);
			check(notes.size() == 0, "missing results");
			$display("test %0d finished", pass);
		end
		stop_test();
	end
endmodule
